//--- design/hmac_unit.sv
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
// What this block does
// - cross: low first half times high second
// - high: high first half times high second
// - signed product plus target, 33-bit sum
// - unsigned product plus target, carry kept
// - modulo signed writes low 32 bits
// - modulo unsigned writes low 32, carry dropped
// - signed overflow: signs agree, sum sign differs
// - negative overflow loads most negative value
// - positive overflow loads largest positive value
// - unsigned carry saturates to all ones
// - record bit updates condition field zero
// - overflow enable updates summary and overflow
module hmac_unit
   import hmac_pkg::*;
#(
   parameter int DATA_W = 32
)
(
   // apb clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // apb request
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [DATA_W-1:0] pwdata,
   // apb answer
   output logic                   pready,
   output logic [DATA_W-1:0]      prdata,
   output logic                   pslverr,
   // status seen by the core
   output logic [3:0]             condition_field_zero,
   output logic                   overflow_flag,
   output logic                   summary_overflow
);

   logic [31:0] first_source_reg_r;
   logic [31:0] first_source_reg_nxt;
   logic [31:0] second_source_reg_r;
   logic [31:0] second_source_reg_nxt;
   logic [31:0] target_accumulator_reg_r;
   logic [31:0] target_accumulator_reg_nxt;
   hmac_ctrl_s  ctrl_r;
   hmac_ctrl_s  ctrl_nxt;
   logic [3:0]  cr0_r;
   logic [3:0]  cr0_nxt;
   logic        ov_r;
   logic        ov_nxt;
   logic        so_r;
   logic        so_nxt;
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;

   logic        acc_wr;
   logic        setup_rd;
   logic        go;
   hmac_ctrl_s  wr_ctrl;
   hmac_res_s   res;

   // address decode shared by the write path, read path and error answer
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      mapped = hit(a, HMAC_OFF_FIRST) || hit(a, HMAC_OFF_SECOND) ||
               hit(a, HMAC_OFF_TARGET) || hit(a, HMAC_OFF_CTRL) ||
               hit(a, HMAC_OFF_STATUS);
   endfunction

   // go is a strobe and is not stored, so it reads back as zero
   function automatic logic [31:0] ctrl_word(input hmac_ctrl_s c);
      logic [31:0] w;
      w = HMAC_RST_WORD;
      w[HMAC_CTRL_HIGH_BIT]   = (c.sel == HMAC_SEL_HIGH);
      w[HMAC_CTRL_UNS_BIT]    = c.is_unsigned;
      w[HMAC_CTRL_SAT_BIT]    = c.saturate;
      w[HMAC_CTRL_OE_BIT]     = c.oe;
      w[HMAC_CTRL_RECORD_BIT] = c.record_bit;
      ctrl_word = w;
   endfunction

   // the multiply-accumulate itself; one cycle, so the multiplier is the timing path
   function automatic hmac_res_s mac(input logic [31:0] a,
                                     input logic [31:0] b,
                                     input logic [31:0] t,
                                     input hmac_ctrl_s  c,
                                     input logic        so_in);
      logic [15:0] ha;
      logic [15:0] hb;
      logic [31:0] prod;
      logic [32:0] temp;
      logic        sovf;
      hmac_res_s   r;
      hb = b[31:16];
      if (c.sel == HMAC_SEL_HIGH)
      begin
         ha = a[31:16];
      end
      else
      begin
         ha = a[15:0];
      end
      if (c.is_unsigned)
      begin
         prod = {16'h0000, ha} * {16'h0000, hb};
         temp = {1'b0, prod} + {1'b0, t};
         sovf = 1'b0;
      end
      else
      begin
         prod = 32'($signed(ha) * $signed(hb));
         temp = {prod[31], prod} + {t[31], t};
         sovf = (prod[31] == t[31]) && (t[31] != temp[31]);
      end
      r.ovf = c.is_unsigned ? temp[32] : sovf;
      r.value = temp[31:0];
      if (c.saturate && c.is_unsigned && temp[32])
      begin
         r.value = HMAC_SAT_UNS;
      end
      else if (c.saturate && !c.is_unsigned && sovf)
      begin
         // signs agreed, so the prior target's sign says which side was crossed
         r.value = t[31] ? HMAC_SAT_NEG : HMAC_SAT_POS;
      end
      r.ov = r.ovf;
      r.so = so_in | r.ovf;
      r.cr0 = {r.value[31], !r.value[31] && (r.value != HMAC_RST_WORD),
               r.value == HMAC_RST_WORD, c.oe ? r.so : so_in};
      mac = r;
   endfunction

   // zero wait state slave
   assign pready   = (HMAC_WAIT_CYCLES == 0);
   assign acc_wr   = psel && penable && pwrite;
   assign setup_rd = psel && !penable && !pwrite;
   // unmapped places answer with an error and read as zero
   assign pslverr  = psel && penable && !mapped(paddr);
   assign prdata   = prdata_r;

   assign condition_field_zero = cr0_r;
   assign overflow_flag        = ov_r;
   assign summary_overflow     = so_r;

   always_comb
   begin
      wr_ctrl.sel         = pwdata[HMAC_CTRL_HIGH_BIT] ? HMAC_SEL_HIGH : HMAC_SEL_CROSS;
      wr_ctrl.is_unsigned = pwdata[HMAC_CTRL_UNS_BIT];
      wr_ctrl.saturate    = pwdata[HMAC_CTRL_SAT_BIT];
      wr_ctrl.oe          = pwdata[HMAC_CTRL_OE_BIT];
      wr_ctrl.record_bit  = pwdata[HMAC_CTRL_RECORD_BIT];
   end

   // a go write runs with the mode bits written alongside it
   assign go  = acc_wr && hit(paddr, HMAC_OFF_CTRL) && pwdata[HMAC_CTRL_GO_BIT];
   // the result is formed every cycle; only a go write commits it
   assign res = mac(first_source_reg_r, second_source_reg_r,
                    target_accumulator_reg_r, wr_ctrl, so_r);

   // operand registers and the accumulator
   always_comb
   begin
      first_source_reg_nxt       = first_source_reg_r;
      second_source_reg_nxt      = second_source_reg_r;
      target_accumulator_reg_nxt = target_accumulator_reg_r;
      ctrl_nxt                   = ctrl_r;
      if (acc_wr && hit(paddr, HMAC_OFF_FIRST))
      begin
         first_source_reg_nxt = pwdata;
      end
      if (acc_wr && hit(paddr, HMAC_OFF_SECOND))
      begin
         second_source_reg_nxt = pwdata;
      end
      if (acc_wr && hit(paddr, HMAC_OFF_TARGET))
      begin
         target_accumulator_reg_nxt = pwdata;
      end
      if (acc_wr && hit(paddr, HMAC_OFF_CTRL))
      begin
         ctrl_nxt = wr_ctrl;
      end
      // a go write lands on the control register, so it never races a target write
      if (go)
      begin
         target_accumulator_reg_nxt = res.value;
      end
   end

   // flags clear by writing one; an update in the same cycle wins
   always_comb
   begin
      cr0_nxt = cr0_r;
      ov_nxt  = ov_r;
      so_nxt  = so_r;
      if (acc_wr && hit(paddr, HMAC_OFF_STATUS))
      begin
         if (pwdata[HMAC_ST_OV_BIT])
         begin
            ov_nxt = 1'b0;
         end
         if (pwdata[HMAC_ST_SO_BIT])
         begin
            so_nxt = 1'b0;
         end
      end
      if (go)
      begin
         if (wr_ctrl.oe)
         begin
            ov_nxt = res.ov;
            so_nxt = res.so;
         end
         if (wr_ctrl.record_bit)
         begin
            cr0_nxt = res.cr0;
         end
      end
   end

   // read data is captured in the setup cycle and held through the access
   always_comb
   begin
      prdata_nxt = prdata_r;
      if (setup_rd)
      begin
         prdata_nxt = HMAC_RST_WORD;
         if (hit(paddr, HMAC_OFF_FIRST))
         begin
            prdata_nxt = first_source_reg_r;
         end
         else if (hit(paddr, HMAC_OFF_SECOND))
         begin
            prdata_nxt = second_source_reg_r;
         end
         else if (hit(paddr, HMAC_OFF_TARGET))
         begin
            prdata_nxt = target_accumulator_reg_r;
         end
         else if (hit(paddr, HMAC_OFF_CTRL))
         begin
            prdata_nxt = ctrl_word(ctrl_r);
         end
         else if (hit(paddr, HMAC_OFF_STATUS))
         begin
            prdata_nxt[HMAC_ST_CR0_LSB +: 4] = cr0_r;
            prdata_nxt[HMAC_ST_OV_BIT]       = ov_r;
            prdata_nxt[HMAC_ST_SO_BIT]       = so_r;
         end
      end
   end

   // operands only move on a bus write or a go
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         first_source_reg_r       <= HMAC_RST_WORD;
         second_source_reg_r      <= HMAC_RST_WORD;
         target_accumulator_reg_r <= HMAC_RST_WORD;
         ctrl_r                   <= '0;
      end
      else
      begin
         first_source_reg_r       <= first_source_reg_nxt;
         second_source_reg_r      <= second_source_reg_nxt;
         target_accumulator_reg_r <= target_accumulator_reg_nxt;
         ctrl_r                   <= ctrl_nxt;
      end
   end

   // flags keep their value until an update or a one-to-clear write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cr0_r <= HMAC_RST_CR0;
         ov_r  <= 1'b0;
         so_r  <= 1'b0;
      end
      else
      begin
         cr0_r <= cr0_nxt;
         ov_r  <= ov_nxt;
         so_r  <= so_nxt;
      end
   end

   // read data moves only at a read setup, so a long access still sees it stable
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_r <= HMAC_RST_WORD;
      end
      else
      begin
         prdata_r <= prdata_nxt;
      end
   end

endmodule

//--- design/hmac_pkg.sv
package hmac_pkg;

   // register byte offsets
   localparam logic [7:0] HMAC_OFF_FIRST  = 8'h00;
   localparam logic [7:0] HMAC_OFF_SECOND = 8'h04;
   localparam logic [7:0] HMAC_OFF_TARGET = 8'h08;
   localparam logic [7:0] HMAC_OFF_CTRL   = 8'h0c;
   localparam logic [7:0] HMAC_OFF_STATUS = 8'h10;

   // control field positions
   localparam int HMAC_CTRL_GO_BIT     = 0;
   localparam int HMAC_CTRL_HIGH_BIT   = 1;
   localparam int HMAC_CTRL_UNS_BIT    = 2;
   localparam int HMAC_CTRL_SAT_BIT    = 3;
   localparam int HMAC_CTRL_OE_BIT     = 4;
   localparam int HMAC_CTRL_RECORD_BIT = 5;

   // status field positions
   localparam int HMAC_ST_CR0_LSB = 0;
   localparam int HMAC_ST_OV_BIT  = 8;
   localparam int HMAC_ST_SO_BIT  = 9;

   // reset values
   localparam logic [31:0] HMAC_RST_WORD = 32'h0000_0000;
   localparam logic [3:0]  HMAC_RST_CR0  = 4'h0;

   // saturation values
   localparam logic [31:0] HMAC_SAT_NEG = 32'h8000_0000;
   localparam logic [31:0] HMAC_SAT_POS = 32'h7fff_ffff;
   localparam logic [31:0] HMAC_SAT_UNS = 32'hffff_ffff;

   // timing: every access completes with no wait state
   localparam int HMAC_WAIT_CYCLES = 0;

   typedef enum logic {HMAC_SEL_CROSS, HMAC_SEL_HIGH} hmac_sel_e;

   typedef struct packed {
      logic      record_bit;
      logic      oe;
      logic      saturate;
      logic      is_unsigned;
      hmac_sel_e sel;
   } hmac_ctrl_s;

   typedef struct packed {
      logic [31:0] value;
      logic        ovf;
      logic [3:0]  cr0;
      logic        ov;
      logic        so;
   } hmac_res_s;

endpackage

//--- test/hmac_core_model.sv
`timescale 1ns/1ps
module hmac_core_model
(
   // clock
   input wire logic         pclk,
   // apb request
   output logic             psel = 1'b0,
   output logic             penable = 1'b0,
   output logic             pwrite = 1'b0,
   output logic [7:0]       paddr = 8'h00,
   output logic [31:0]      pwdata = 32'h0,
   // apb answer
   input wire logic         pready,
   input wire logic [31:0]  prdata,
   input wire logic         pslverr
);
   // idle edge first, so psel is never driven twice in one step
   task automatic xfer(input logic [7:0] a, input logic [31:0] d, input logic w,
                       output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines flip so stale values cannot pass for held ones
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule

//--- test/hmac_unit_asserts.sv
`timescale 1ns/1ps
module hmac_unit_asserts
   import hmac_pkg::*;
(
   // apb side
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   // status
   input wire logic [3:0]  condition_field_zero,
   input wire logic        overflow_flag,
   input wire logic        summary_overflow
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic wr_st;
   logic go;
   assign wr_st = psel && penable && pwrite && paddr == HMAC_OFF_STATUS;
   assign go = psel && penable && pwrite && paddr == HMAC_OFF_CTRL && pwdata[HMAC_CTRL_GO_BIT];
   chk_err_unmapped: assert property (psel && penable |->
      pslverr == (paddr > HMAC_OFF_STATUS || paddr[1:0] != 2'b00)) else $error("bad pslverr");
   chk_ready_high: assert property (psel && penable |-> pready)
      else $error("slave not ready");
   chk_ov_hold: assert property (!go && !wr_st |=> $stable(overflow_flag))
      else $error("overflow flag moved");
   chk_so_sticky: assert property (summary_overflow && !wr_st |=> summary_overflow)
      else $error("summary overflow dropped");
   chk_so_follows: assert property ($rose(overflow_flag) |-> summary_overflow)
      else $error("summary overflow not set");
   chk_oe_off: assert property (go && !pwdata[HMAC_CTRL_OE_BIT] |=> $stable(overflow_flag)
      && $stable(summary_overflow)) else $error("flags moved without enable");
   chk_cr0_hold: assert property (!(go && pwdata[HMAC_CTRL_RECORD_BIT])
      |=> $stable(condition_field_zero)) else $error("field zero moved");
   chk_cr0_sign: assert property (go && pwdata[HMAC_CTRL_RECORD_BIT]
      |=> $onehot(condition_field_zero[3:1])) else $error("field zero sign bad");
   chk_cr0_so: assert property (go && pwdata[HMAC_CTRL_RECORD_BIT]
      |=> condition_field_zero[0] == summary_overflow) else $error("field zero copy bad");
   cover property (go && pwdata[HMAC_CTRL_SAT_BIT]);
   cover property (psel && penable && pslverr);
   cover property ($rose(overflow_flag));
endmodule
bind hmac_unit hmac_unit_asserts chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .prdata(prdata), .pslverr(pslverr), .condition_field_zero(condition_field_zero),
   .overflow_flag(overflow_flag), .summary_overflow(summary_overflow));

//--- test/hmac_unit_tb_top.sv
`timescale 1ns/1ps
module hmac_unit_tb_top
   import hmac_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ov, so, e, x_ov, x_so;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0] cr0, x_cr0;
   int mismatches, n_checks;
   logic [31:0] ca [6] = '{32'h7fff, 32'h80000000, 32'hffff0000, 32'h7fff, 32'hffff, 0};
   logic [31:0] cb [6] = '{32'h7fff0000, 32'h7fff0000, 32'hffff0000, 32'h7fff0000,
                           32'hffff0000, 0};
   logic [31:0] ct [6] = '{32'h7fffffff, 32'h80000000, 32'hffffffff, 32'h7fffffff,
                           32'hffffffff, 0};
   logic [5:0] cc [6] = '{6'h39, 6'h3b, 6'h3f, 6'h31, 6'h35, 6'h21};
   hmac_unit dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .condition_field_zero(cr0), .overflow_flag(ov),
      .summary_overflow(so));
   hmac_core_model pm_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task complete_run;
      if (mismatches == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // returns overflow bit above the value written back
   function automatic logic [32:0] mac_ref(input logic [31:0] a, b, t, input logic [5:0] c);
      logic [15:0] ha;
      logic [31:0] p;
      logic [32:0] s;
      logic f;
      ha = c[1] ? a[31:16] : a[15:0];
      if (c[2])
         p = ha * b[31:16];
      else
         p = $signed(ha) * $signed(b[31:16]);
      s = c[2] ? {1'b0, t} + {1'b0, p} : {t[31], t} + {p[31], p};
      f = c[2] ? s[32] : (p[31] == t[31] && t[31] != s[31]);
      if (!(c[3] && f))
         return {f, s[31:0]};
      return {f, c[2] ? 32'hffffffff : t[31] ? 32'h80000000 : 32'h7fffffff};
   endfunction
   task automatic op(input logic [31:0] a, b, t, input logic [5:0] c);
      logic [32:0] r;
      pm_u.xfer(HMAC_OFF_FIRST, a, 1'b1, q, e);
      pm_u.xfer(HMAC_OFF_SECOND, b, 1'b1, q, e);
      pm_u.xfer(HMAC_OFF_TARGET, t, 1'b1, q, e);
      pm_u.xfer(HMAC_OFF_CTRL, {26'h0, c}, 1'b1, q, e);
      // a control write without go must leave target and flags alone
      r = c[0] ? mac_ref(a, b, t, c) : {1'b0, t};
      x_ov = (c[0] && c[4]) ? r[32] : x_ov;
      x_so = x_so | (c[0] & c[4] & r[32]);
      if (c[0] && c[5])
         x_cr0 = {r[31], !r[31] && r[31:0] != 0, r[31:0] == 0, x_so};
      pm_u.xfer(HMAC_OFF_TARGET, 32'h0, 1'b0, q, e);
      cmp(q, r[31:0]);
      pm_u.xfer(HMAC_OFF_STATUS, 32'h0, 1'b0, q, e);
      cmp(q, {22'h0, x_so, x_ov, 4'h0, x_cr0});
      cmp({28'h0, cr0}, {28'h0, x_cr0});
      cmp({30'h0, so, ov}, {30'h0, x_so, x_ov});
      pm_u.xfer(HMAC_OFF_CTRL, 32'h0, 1'b0, q, e);
      cmp(q, {26'h0, c[5:1], 1'b0});
      if ($urandom_range(3) == 0)
      begin
         pm_u.xfer(HMAC_OFF_STATUS, 32'h300, 1'b1, q, e);
         x_ov = 1'b0;
         x_so = 1'b0;
         // the clear lands at the access edge; look once the flags have settled
         @(negedge pclk);
         cmp({30'h0, so, ov}, 32'h0);
      end
   endtask
   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   initial
   begin
      #100000;
      mismatches++;
      complete_run;
   end
   initial
   begin
      presetn = 1'b0;
      {x_cr0, x_ov, x_so} = 6'h0;
      void'($urandom(32'h31ab));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 5; i++)
      begin
         pm_u.xfer(8'(i * 4), 32'h0, 1'b0, q, e);
         cmp(q, 32'h0);
      end
      // unmapped place: write dropped, read gives zero and an error
      pm_u.xfer(8'h14, 32'h1, 1'b1, q, e);
      cmp({31'h0, e}, 32'h1);
      pm_u.xfer(8'h14, 32'h0, 1'b0, q, e);
      cmp({q[30:0], e}, 32'h1);
      for (int i = 0; i < 6; i++)
         op(ca[i], cb[i], ct[i], cc[i]);
      for (int i = 0; i < 60; i++)
         op($urandom, $urandom, $urandom, {5'($urandom), ($urandom_range(7) != 0)});
      complete_run;
   end
endmodule
